// File: design/rwt_host.sv
// module: host controller end issuing single register reads and writes over the link
`default_nettype none
module rwt_host
   import rwt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   rwt_link_if.host link,
   input wire logic cmdValid,
   input wire rwt_pkg::rwt_cmd_t cmdKind,
   input wire logic [7:0] cmdAddr,
   input wire logic [15:0] cmdData,
   output logic cmdReady,
   output logic respValid,
   output logic [15:0] respData
);
   import rwt_pkg::*;

   typedef enum logic [1:0] {RWT_H_IDLE, RWT_H_WAIT} rwt_hstate_t;

   typedef struct packed {
      rwt_hstate_t st;
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] data;
      logic ready;
      logic respValid;
      logic [15:0] resp;
   } rwt_host_state_t;

   rwt_host_state_t h_r;
   rwt_host_state_t h_nxt;

   // make written values legal: even starts, odd sizes of at least 1, line blanking at least 21
   function automatic logic [15:0] legalise(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (a == ADDR_FIRST_ROW || a == ADDR_FIRST_COL) begin
         v[0] = 1'b0;
      end else if (a == ADDR_WIN_HEIGHT || a == ADDR_WIN_WIDTH) begin
         v[0] = 1'b1;
      end else if (a == ADDR_LINE_BLANK && d < 16'h0015) begin
         v = 16'h0015;
      end
      return v;
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      h_nxt = h_r;
      h_nxt.wr = 1'b0;
      h_nxt.rd = 1'b0;
      h_nxt.respValid = 1'b0;
      case (h_r.st)
         RWT_H_IDLE: begin
            if (cmdValid && h_r.ready && cmdKind == RWT_CMD_WRITE) begin
               h_nxt.wr = 1'b1;
               h_nxt.addr = cmdAddr;
               h_nxt.data = legalise(cmdAddr, cmdData);
            end else if (cmdValid && h_r.ready && cmdKind == RWT_CMD_READ) begin
               h_nxt.rd = 1'b1;
               h_nxt.addr = cmdAddr;
               h_nxt.ready = 1'b0;
               h_nxt.st = RWT_H_WAIT;
            end
         end
         default: begin
            // read in flight; no new command until its answer
            if (link.rdValid) begin
               h_nxt.respValid = 1'b1;
               h_nxt.resp = link.rdData;
               h_nxt.ready = 1'b1;
               h_nxt.st = RWT_H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         h_r <= '0;
         h_r.st <= RWT_H_IDLE;
         h_r.ready <= 1'b1;
      end else begin
         h_r <= h_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   assign link.wrStrobe = h_r.wr;
   assign link.rdStrobe = h_r.rd;
   assign link.addr = h_r.addr;
   assign link.wrData = h_r.data;
   assign cmdReady = h_r.ready;
   assign respValid = h_r.respValid;
   assign respData = h_r.resp;
endmodule : rwt_host
`default_nettype wire

// File: design/rwt_link_if.sv
// interface: register access link between the host controller and the sensor register bank
`default_nettype none
interface rwt_link_if;
   logic wrStrobe;
   logic rdStrobe;
   logic [7:0] addr;
   logic [15:0] wrData;
   logic [15:0] rdData;
   logic rdValid;
   modport device (input wrStrobe, input rdStrobe, input addr, input wrData, output rdData, output rdValid);
   modport host (output wrStrobe, output rdStrobe, output addr, output wrData, input rdData, input rdValid);
endinterface : rwt_link_if
`default_nettype wire

// File: design/rwt_pkg.sv
// package: register map, reset values and field positions of the readout timing register bank
`default_nettype none
package rwt_pkg;
   localparam logic [7:0] ADDR_IDENT = 8'h00;
   localparam logic [7:0] ADDR_FIRST_ROW = 8'h01;
   localparam logic [7:0] ADDR_FIRST_COL = 8'h02;
   localparam logic [7:0] ADDR_WIN_HEIGHT = 8'h03;
   localparam logic [7:0] ADDR_WIN_WIDTH = 8'h04;
   localparam logic [7:0] ADDR_LINE_BLANK = 8'h05;
   localparam logic [7:0] ADDR_FRAME_BLANK = 8'h06;
   localparam logic [7:0] ADDR_OUT_CTRL = 8'h07;
   localparam logic [7:0] ADDR_EXPO_HIGH = 8'h08;
   localparam logic [7:0] ADDR_EXPO_LOW = 8'h09;
   localparam logic [7:0] ADDR_RESTART = 8'h0b;
   localparam logic [7:0] ADDR_READ_MODE = 8'h20;
   localparam logic [7:0] ADDR_TEST_WORD = 8'h32;
   // identification value is arbitrary, chosen only to be recognisable
   localparam logic [15:0] IDENT_VALUE = 16'h5a3c;
   localparam logic [10:0] RST_FIRST_ROW = 11'h014;
   localparam logic [11:0] RST_FIRST_COL = 12'h020;
   localparam logic [10:0] RST_WIN_HEIGHT = 11'h5ff;
   localparam logic [10:0] RST_WIN_WIDTH = 11'h7ff;
   localparam logic [10:0] RST_LINE_BLANK = 11'h08e;
   localparam logic [10:0] RST_FRAME_BLANK = 11'h019;
   localparam logic [15:0] RST_OUT_CTRL = 16'h0002;
   localparam logic [15:0] RST_EXPO_HIGH = 16'h0000;
   localparam logic [15:0] RST_EXPO_LOW = 16'h0619;
   localparam logic [15:0] RST_READ_MODE = 16'h0000;
   localparam logic [9:0] RST_TEST_WORD = 10'h000;
   localparam int OC_HOLD_BIT = 0;
   localparam int OC_ENABLE_BIT = 1;
   localparam int OC_TESTPAT_BIT = 6;
   localparam int RM_ALLFRAMES_BIT = 0;
   localparam int RESTART_BIT = 0;
   localparam logic [15:0] OUT_CTRL_MASK = 16'h0043;
   localparam int PIX_W = 10;
   // host-side command codes
   typedef enum logic [1:0] {RWT_CMD_IDLE, RWT_CMD_WRITE, RWT_CMD_READ} rwt_cmd_t;
endpackage : rwt_pkg
`default_nettype wire

// File: design/rwt_regs.sv
// module: sensor readout window and timing register bank with frame timing generator
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module rwt_regs
   import rwt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   rwt_link_if.device link,
   input wire logic [rwt_pkg::PIX_W-1:0] pixelIn,
   output logic frameValid,
   output logic lineValid,
   output logic [rwt_pkg::PIX_W-1:0] pixelOut,
   output logic analogPowerDown,
   output logic [31:0] exposureRows,
   output logic [10:0] rowAddr,
   output logic [11:0] colAddr
);
   import rwt_pkg::*;

   typedef enum logic [1:0] {RWT_ST_ACTIVE, RWT_ST_HBLANK, RWT_ST_VBLANK} rwt_phase_t;

   // frame-affecting settings, programmed and in use
   typedef struct packed {
      logic [10:0] height;
      logic [10:0] width;
      logic [10:0] lineBlank;
      logic [10:0] frameBlank;
      logic [15:0] expoHigh;
      logic [15:0] expoLow;
   } rwt_frame_cfg_t;

   typedef struct packed {
      logic [10:0] firstRow;
      logic [11:0] firstCol;
      rwt_frame_cfg_t prog;
      rwt_frame_cfg_t live;
      logic [10:0] liveFirstRow;
      logic [11:0] liveFirstCol;
      logic [15:0] outCtrl;
      logic [15:0] readMode;
      logic [9:0] testWord;
      logic restart;
      logic changed;
      logic badFrame;
      rwt_phase_t phase;
      logic [10:0] rowCnt;
      logic [11:0] colCnt; // one bit wider than a size so a blank row of width plus blanking fits
      logic invert;
      logic [15:0] rdData;
      logic rdValid;
      logic frameValid;
      logic lineValid;
      logic [PIX_W-1:0] pixel;
      logic [31:0] expo;
   } rwt_state_t;

   rwt_state_t s_r;
   rwt_state_t s_nxt;

   // widen a narrow field to the read data width, upper bits zero
   function automatic logic [15:0] zext11(input logic [10:0] v);
      return {5'h00, v};
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.rdValid = 1'b0;
      // register writes; the bus has no error answer, so unmapped writes vanish
      if (link.wrStrobe) begin
         if (link.addr == ADDR_FIRST_ROW) begin
            s_nxt.firstRow = link.wrData[10:0];
         end else if (link.addr == ADDR_FIRST_COL) begin
            s_nxt.firstCol = link.wrData[11:0];
         end else if (link.addr == ADDR_WIN_HEIGHT) begin
            s_nxt.prog.height = link.wrData[10:0];
         end else if (link.addr == ADDR_WIN_WIDTH) begin
            s_nxt.prog.width = link.wrData[10:0];
         end else if (link.addr == ADDR_LINE_BLANK) begin
            s_nxt.prog.lineBlank = link.wrData[10:0];
         end else if (link.addr == ADDR_FRAME_BLANK) begin
            s_nxt.prog.frameBlank = link.wrData[10:0];
         end else if (link.addr == ADDR_OUT_CTRL) begin
            s_nxt.outCtrl = link.wrData & OUT_CTRL_MASK;
         end else if (link.addr == ADDR_EXPO_HIGH) begin
            s_nxt.prog.expoHigh = link.wrData;
         end else if (link.addr == ADDR_EXPO_LOW) begin
            s_nxt.prog.expoLow = link.wrData;
         end else if (link.addr == ADDR_RESTART) begin
            s_nxt.restart = s_r.restart | link.wrData[RESTART_BIT];
         end else if (link.addr == ADDR_READ_MODE) begin
            s_nxt.readMode = {15'h0000, link.wrData[RM_ALLFRAMES_BIT]};
         end else if (link.addr == ADDR_TEST_WORD) begin
            s_nxt.testWord = link.wrData[PIX_W-1:0];
         end
         // window or line blanking change marks the next frame bad
         if (link.addr >= ADDR_FIRST_ROW && link.addr <= ADDR_LINE_BLANK) begin
            s_nxt.changed = 1'b1;
         end
      end
      // register reads answer one cycle later; identification is constant
      if (link.rdStrobe) begin
         s_nxt.rdValid = 1'b1;
         if (link.addr == ADDR_IDENT) begin
            s_nxt.rdData = IDENT_VALUE;
         end else if (link.addr == ADDR_FIRST_ROW) begin
            s_nxt.rdData = zext11(s_r.firstRow);
         end else if (link.addr == ADDR_FIRST_COL) begin
            s_nxt.rdData = {4'h0, s_r.firstCol};
         end else if (link.addr == ADDR_WIN_HEIGHT) begin
            s_nxt.rdData = zext11(s_r.prog.height);
         end else if (link.addr == ADDR_WIN_WIDTH) begin
            s_nxt.rdData = zext11(s_r.prog.width);
         end else if (link.addr == ADDR_LINE_BLANK) begin
            s_nxt.rdData = zext11(s_r.prog.lineBlank);
         end else if (link.addr == ADDR_FRAME_BLANK) begin
            s_nxt.rdData = zext11(s_r.prog.frameBlank);
         end else if (link.addr == ADDR_OUT_CTRL) begin
            s_nxt.rdData = s_r.outCtrl;
         end else if (link.addr == ADDR_EXPO_HIGH) begin
            s_nxt.rdData = s_r.prog.expoHigh;
         end else if (link.addr == ADDR_EXPO_LOW) begin
            s_nxt.rdData = s_r.prog.expoLow;
         end else if (link.addr == ADDR_RESTART) begin
            s_nxt.rdData = {15'h0000, s_r.restart};
         end else if (link.addr == ADDR_READ_MODE) begin
            s_nxt.rdData = s_r.readMode;
         end else if (link.addr == ADDR_TEST_WORD) begin
            s_nxt.rdData = {6'h00, s_r.testWord};
         end else begin
            s_nxt.rdData = 16'h0000;
         end
      end

      // frame timing; stopped and parked in blanking while disabled
      s_nxt.frameValid = 1'b0;
      s_nxt.lineValid = 1'b0;
      s_nxt.pixel = '0;
      if (!s_r.outCtrl[OC_ENABLE_BIT]) begin
         s_nxt.phase = RWT_ST_VBLANK;
         s_nxt.rowCnt = '0;
         s_nxt.colCnt = '0;
      end else if (s_r.restart) begin
         // abandon the frame; the restart bit drops once this is done
         s_nxt.phase = RWT_ST_ACTIVE;
         s_nxt.rowCnt = '0;
         s_nxt.colCnt = '0;
         s_nxt.invert = 1'b0;
         s_nxt.badFrame = 1'b1;
         if (!(link.wrStrobe && link.addr == ADDR_RESTART && link.wrData[RESTART_BIT])) begin
            s_nxt.restart = 1'b0;
         end
         if (!s_r.outCtrl[OC_HOLD_BIT]) begin
            s_nxt.live = s_r.prog;
            s_nxt.liveFirstRow = s_r.firstRow;
            s_nxt.liveFirstCol = s_r.firstCol;
            // a window write landing in this very cycle still marks the following frame bad
            s_nxt.changed = link.wrStrobe && link.addr >= ADDR_FIRST_ROW && link.addr <= ADDR_LINE_BLANK;
         end
      end else begin
         case (s_r.phase)
            RWT_ST_ACTIVE: begin
               s_nxt.frameValid = 1'b1;
               s_nxt.lineValid = 1'b1;
               s_nxt.invert = ~s_r.invert;
               // test word first, its inverse next, alternating along the line
               if (s_r.outCtrl[OC_TESTPAT_BIT]) begin
                  s_nxt.pixel = s_r.invert ? ~s_r.testWord : s_r.testWord;
               end else begin
                  s_nxt.pixel = pixelIn;
               end
               if (s_r.colCnt == {1'b0, s_r.live.width}) begin
                  s_nxt.colCnt = '0;
                  s_nxt.phase = RWT_ST_HBLANK;
               end else begin
                  s_nxt.colCnt = s_r.colCnt + 12'h001;
               end
            end
            RWT_ST_HBLANK: begin
               s_nxt.frameValid = 1'b1;
               s_nxt.invert = 1'b0;
               if (s_r.colCnt == {1'b0, s_r.live.lineBlank - 11'h001}) begin
                  s_nxt.colCnt = '0;
                  if (s_r.rowCnt == s_r.live.height) begin
                     s_nxt.rowCnt = '0;
                     s_nxt.phase = RWT_ST_VBLANK;
                  end else begin
                     s_nxt.rowCnt = s_r.rowCnt + 11'h001;
                     s_nxt.phase = RWT_ST_ACTIVE;
                  end
               end else begin
                  s_nxt.colCnt = s_r.colCnt + 12'h001;
               end
            end
            default: begin
               // each blank row lasts one full line time; summed at 12 bits so large windows do not wrap
               if (s_r.colCnt == {1'b0, s_r.live.width} + {1'b0, s_r.live.lineBlank}) begin
                  s_nxt.colCnt = '0;
                  if (s_r.rowCnt >= s_r.live.frameBlank) begin
                     // frame boundary: pending settings load unless held
                     s_nxt.rowCnt = '0;
                     s_nxt.phase = RWT_ST_ACTIVE;
                     s_nxt.badFrame = 1'b0;
                     if (!s_r.outCtrl[OC_HOLD_BIT]) begin
                        s_nxt.live = s_r.prog;
                        s_nxt.liveFirstRow = s_r.firstRow;
                        s_nxt.liveFirstCol = s_r.firstCol;
                        s_nxt.badFrame = s_r.changed;
                        s_nxt.changed = link.wrStrobe && link.addr >= ADDR_FIRST_ROW && link.addr <= ADDR_LINE_BLANK;
                     end
                  end else begin
                     s_nxt.rowCnt = s_r.rowCnt + 11'h001;
                  end
               end else begin
                  s_nxt.colCnt = s_r.colCnt + 12'h001;
               end
            end
         endcase
      end
      // bad frames kept off the output unless all frames are wanted
      if (s_r.badFrame && !s_r.readMode[RM_ALLFRAMES_BIT]) begin
         s_nxt.frameValid = 1'b0;
         s_nxt.lineValid = 1'b0;
         s_nxt.pixel = '0;
      end
      s_nxt.expo = {s_r.live.expoHigh, s_r.live.expoLow};
   end

   //////////////////////////////////////////////////////////////////////////////
   // state register; constants only under reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.firstRow <= RST_FIRST_ROW;
         s_r.firstCol <= RST_FIRST_COL;
         s_r.prog <= {RST_WIN_HEIGHT, RST_WIN_WIDTH, RST_LINE_BLANK, RST_FRAME_BLANK, RST_EXPO_HIGH, RST_EXPO_LOW};
         s_r.live <= {RST_WIN_HEIGHT, RST_WIN_WIDTH, RST_LINE_BLANK, RST_FRAME_BLANK, RST_EXPO_HIGH, RST_EXPO_LOW};
         s_r.liveFirstRow <= RST_FIRST_ROW;
         s_r.liveFirstCol <= RST_FIRST_COL;
         s_r.outCtrl <= RST_OUT_CTRL;
         s_r.readMode <= RST_READ_MODE;
         s_r.testWord <= RST_TEST_WORD;
         s_r.phase <= RWT_ST_VBLANK;
         s_r.expo <= {RST_EXPO_HIGH, RST_EXPO_LOW};
      end else begin
         s_r <= s_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   assign link.rdData = s_r.rdData;
   assign link.rdValid = s_r.rdValid;
   assign frameValid = s_r.frameValid;
   assign lineValid = s_r.lineValid;
   assign pixelOut = s_r.pixel;
   assign analogPowerDown = ~s_r.outCtrl[OC_ENABLE_BIT];
   assign exposureRows = s_r.expo;
   assign rowAddr = s_r.liveFirstRow + s_r.rowCnt; // array row being read
   assign colAddr = s_r.liveFirstCol + s_r.colCnt;
endmodule : rwt_regs
`default_nettype wire

// File: test/rwt_chk.sv
// checker: timed properties on the register access link between host and register bank
`default_nettype none
module rwt_chk
   import rwt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   input wire logic [7:0] addr,
   input wire logic [15:0] wrData,
   input wire logic [15:0] rdData,
   input wire logic rdValid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   //////////////////////////////////////////////////////////////////////////////
   // read handshake: the answer comes exactly one cycle after the request
   chk_read_answer: assert property (rdStrobe |=> rdValid)
      else $error("read request not answered in one cycle");
   chk_valid_cause: assert property (rdValid |-> $past(rdStrobe))
      else $error("read answer without a request");
   // read data contents: fixed identity and zero in unused bits
   chk_ident_value: assert property (rdStrobe && addr == ADDR_IDENT |=> rdData == IDENT_VALUE)
      else $error("identification read wrong");
   chk_row_bits: assert property (rdStrobe && (addr == ADDR_FIRST_ROW || addr == ADDR_WIN_HEIGHT
      || addr == ADDR_WIN_WIDTH) |=> rdData[15:11] == 5'h00)
      else $error("unused bits of row or size set");
   chk_col_bits: assert property (rdStrobe && addr == ADDR_FIRST_COL |=> rdData[15:12] == 4'h0)
      else $error("unused bits of first column set");
   chk_blank_bits: assert property (rdStrobe && (addr == ADDR_LINE_BLANK || addr == ADDR_FRAME_BLANK)
      |=> rdData[15:11] == 5'h00)
      else $error("unused bits of blanking set");
   chk_ctrl_bits: assert property (rdStrobe && addr == ADDR_OUT_CTRL |=> (rdData & ~OUT_CTRL_MASK) == 16'h0000)
      else $error("unused output control bits set");
   // with output enabled, restart clears itself before a read three cycles later can see it
   chk_restart_clear: assert property (wrStrobe && addr == ADDR_RESTART ##3 rdStrobe && addr == ADDR_RESTART
      |=> rdData == 16'h0000)
      else $error("restart bit did not clear");
   // a write to exposure low followed by a read of it three cycles later returns the written word
   chk_expo_readback: assert property (wrStrobe && addr == ADDR_EXPO_LOW ##3 rdStrobe && addr == ADDR_EXPO_LOW
      |=> rdData == $past(wrData, 4))
      else $error("exposure low readback wrong");
   chk_unmapped_zero: assert property (rdStrobe && addr == 8'h0a |=> rdData == 16'h0000)
      else $error("unmapped read not zero");
   // main scenarios reached
   cover property (rdStrobe && addr == ADDR_IDENT);
   cover property (wrStrobe && addr == ADDR_RESTART && wrData[RESTART_BIT]);
   cover property (wrStrobe && addr == ADDR_OUT_CTRL && wrData[OC_HOLD_BIT]);
endmodule // rwt_chk
`default_nettype wire

// File: test/tb_top.sv
// testbench: host end and register bank joined over the link, table of accesses then hand tests
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rwt_pkg::*;
   typedef struct packed {logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e;} rwt_row_t;
   logic clk;
   logic resetn;
   logic cmdValid;
   logic cmdReady;
   logic respValid;
   logic frameValid;
   logic lineValid;
   logic analogPowerDown;
   rwt_cmd_t cmdKind;
   logic [7:0] cmdAddr;
   logic [15:0] cmdData;
   logic [15:0] respData;
   logic [PIX_W-1:0] pixelIn = '0;
   logic [PIX_W-1:0] pixelOut;
   logic [31:0] exposureRows;
   logic [10:0] rowAddr;
   logic [11:0] colAddr;
   int n_errors = 0;
   int n_checks = 0;
   // reset values first, then writes with junk in unused bits; small window keeps frames short
   localparam rwt_row_t ROWS [25] = '{
      '{8'h00, 1'b0, 16'h0, IDENT_VALUE}, '{8'h01, 1'b0, 16'h0, 16'h0014}, '{8'h02, 1'b0, 16'h0, 16'h0020},
      '{8'h03, 1'b0, 16'h0, 16'h05ff}, '{8'h04, 1'b0, 16'h0, 16'h07ff}, '{8'h05, 1'b0, 16'h0, 16'h008e},
      '{8'h06, 1'b0, 16'h0, 16'h0019}, '{8'h07, 1'b0, 16'h0, 16'h0002}, '{8'h08, 1'b0, 16'h0, 16'h0000},
      '{8'h09, 1'b0, 16'h0, 16'h0619}, '{8'h0b, 1'b0, 16'h0, 16'h0000}, '{8'h0a, 1'b0, 16'h0, 16'h0000},
      '{8'h20, 1'b0, 16'h0, 16'h0000}, '{8'h32, 1'b0, 16'h0, 16'h0000},
      '{8'h00, 1'b1, 16'hffff, IDENT_VALUE}, '{8'h01, 1'b1, 16'hf802, 16'h0002},
      '{8'h02, 1'b1, 16'hf004, 16'h0004}, '{8'h03, 1'b1, 16'hf803, 16'h0003},
      '{8'h04, 1'b1, 16'hf807, 16'h0007}, '{8'h05, 1'b1, 16'h0003, 16'h0015},
      '{8'h06, 1'b1, 16'hf802, 16'h0002}, '{8'h08, 1'b1, 16'h0001, 16'h0001},
      '{8'h09, 1'b1, 16'h0003, 16'h0003}, '{8'h0a, 1'b1, 16'hffff, 16'h0000},
      '{8'h32, 1'b1, 16'hfea5, 16'h02a5}};
   //////////////////////////////////////////////////////////////////////////////
   rwt_link_if link();
   rwt_host i_rwt_host(.clk(clk), .resetn(resetn), .link(link), .cmdValid(cmdValid), .cmdKind(cmdKind),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .respValid(respValid), .respData(respData));
   rwt_regs i_rwt_regs(.clk(clk), .resetn(resetn), .link(link), .pixelIn(pixelIn), .frameValid(frameValid),
      .lineValid(lineValid), .pixelOut(pixelOut), .analogPowerDown(analogPowerDown),
      .exposureRows(exposureRows), .rowAddr(rowAddr), .colAddr(colAddr));
   rwt_chk i_rwt_chk(.clk(clk), .resetn(resetn), .wrStrobe(link.wrStrobe), .rdStrobe(link.rdStrobe),
      .addr(link.addr), .wrData(link.wrData), .rdData(link.rdData), .rdValid(link.rdValid));
   //////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock and a moving pixel stream
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      #2;
      pixelIn = pixelIn + 10'h001;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one command, raised once cmdReady is seen high and held for one edge; the leading edge keeps a gap between commands
   task automatic issue(input rwt_cmd_t k, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #2;
      while (cmdReady !== 1'b1 && n < 50) begin
         @(posedge clk);
         #2;
         n++;
      end
      cmdValid = 1'b1;
      cmdKind = k;
      cmdAddr = a;
      cmdData = d;
      @(posedge clk);
      #2;
      cmdValid = 1'b0;
      cmdKind = RWT_CMD_IDLE;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      int n;
      n = 0;
      issue(RWT_CMD_READ, a, 16'h0000);
      while (respValid !== 1'b1 && n < 20) begin
         @(posedge clk);
         #2;
         n++;
      end
      v = respData;
   endtask
   task automatic count_lines(input int span, output int cnt);
      cnt = 0;
      repeat (span) begin
         @(posedge clk);
         #1;
         if (lineValid === 1'b1) cnt++;
      end
   endtask
   // watchdog: the whole run needs a few thousand cycles
   initial begin
      #500000;
      n_errors++;
      give_verdict();
   end
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      int cnt;
      int n;
      resetn = 1'b0;
      cmdValid = 1'b0;
      cmdKind = RWT_CMD_IDLE;
      cmdAddr = 8'h00;
      cmdData = 16'h0000;
      repeat (8) @(posedge clk);
      #2;
      resetn = 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) issue(RWT_CMD_WRITE, ROWS[i].a, ROWS[i].d);
         rd(ROWS[i].a, v);
         check("register", {16'h0, v}, {16'h0, ROWS[i].e});
      end
      $display("register table done");
      // writes sit pending until a boundary, which is far off with reset timing
      check("exposure pending", exposureRows, 32'h00000619);
      issue(RWT_CMD_WRITE, ADDR_RESTART, 16'h0001);
      rd(ADDR_RESTART, v);
      check("restart clear", {16'h0, v}, 32'h0);
      check("first row", {21'h0, rowAddr}, 32'h2);
      check("exposure", exposureRows, 32'h00010003);
      count_lines(150, cnt);
      check("bad frame lines", cnt, 32'd0);
      count_lines(203, cnt);
      check("good frame lines", cnt, 32'd32);
      issue(RWT_CMD_WRITE, ADDR_READ_MODE, 16'h0001);
      issue(RWT_CMD_WRITE, ADDR_RESTART, 16'h0001);
      count_lines(150, cnt);
      check("all frame lines", cnt, 32'd32);
      $display("restart tests done");
      // test pattern from the first column of a fresh line
      issue(RWT_CMD_WRITE, ADDR_OUT_CTRL, 16'h0042);
      n = 0;
      while (lineValid !== 1'b0 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      while (lineValid !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
      for (int k = 0; k < 3; k++) begin
         check("pattern", {22'h0, pixelOut}, k[0] ? 32'h15a : 32'h2a5);
         check("frame valid", {31'h0, frameValid}, 32'h1);
         check("column", {20'h0, colAddr}, 32'h5 + k);
         @(posedge clk);
         #1;
      end
      $display("pattern test done");
      // hold keeps old exposure across boundaries; release lets it in at the next one
      issue(RWT_CMD_WRITE, ADDR_OUT_CTRL, 16'h0043);
      issue(RWT_CMD_WRITE, ADDR_EXPO_LOW, 16'h0007);
      repeat (450) @(posedge clk);
      #1;
      check("exposure held", exposureRows, 32'h00010003);
      issue(RWT_CMD_WRITE, ADDR_OUT_CTRL, 16'h0042);
      n = 0;
      while (exposureRows !== 32'h00010007 && n < 250) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("exposure released", exposureRows, 32'h00010007);
      $display("hold test done");
      issue(RWT_CMD_WRITE, ADDR_OUT_CTRL, 16'h0040);
      repeat (3) @(posedge clk);
      check("power down", {31'h0, analogPowerDown}, 32'h1);
      count_lines(250, cnt);
      check("stopped lines", cnt, 32'd0);
      issue(RWT_CMD_WRITE, ADDR_OUT_CTRL, 16'h0042);
      repeat (3) @(posedge clk);
      check("power up", {31'h0, analogPowerDown}, 32'h0);
      $display("enable test done");
      // second reset mid-run restores reset values
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      check("reset exposure", exposureRows, 32'h00000619);
      check("reset row", {21'h0, rowAddr}, 32'h14);
      check("reset frame", {31'h0, frameValid}, 32'h0);
      #2;
      resetn = 1'b1;
      rd(ADDR_FIRST_COL, v);
      check("reset column", {16'h0, v}, 32'h20);
      $display("reset test done");
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
